/* common/tlsc_pkg.sv */
package tlsc_pkg;

   // ****************************************
   // register map: index, byte address = 4 x index
   // ****************************************
   localparam logic [15:0] IDX_LIM_SEL   = 16'h3504;
   localparam logic [15:0] IDX_STOP_SEL  = 16'h3505;
   localparam logic [15:0] IDX_UV_SEL    = 16'h3508;
   localparam logic [15:0] IDX_IMM_FORCE = 16'h3511;
   localparam logic [15:0] IDX_STATUS    = 16'h3600;
   localparam logic [15:0] IDX_CTRL      = 16'h3601;
   localparam logic [15:0] ADR_LIM_SEL   = {IDX_LIM_SEL[13:0], 2'h0};
   localparam logic [15:0] ADR_STOP_SEL  = {IDX_STOP_SEL[13:0], 2'h0};
   localparam logic [15:0] ADR_UV_SEL    = {IDX_UV_SEL[13:0], 2'h0};
   localparam logic [15:0] ADR_IMM_FORCE = {IDX_IMM_FORCE[13:0], 2'h0};
   localparam logic [15:0] ADR_STATUS    = {IDX_STATUS[13:0], 2'h0};
   localparam logic [15:0] ADR_CTRL      = {IDX_CTRL[13:0], 2'h0};

   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic [15:0] RST_LIM_SEL   = 16'h0001;
   localparam logic [15:0] RST_STOP_SEL  = 16'h0000;
   localparam logic [15:0] RST_UV_SEL    = 16'h0001;
   localparam logic [15:0] RST_IMM_FORCE = 16'h0000;
   localparam logic [1:0]  LIM_BOTH      = 2'h0;
   localparam logic [1:0]  LIM_OFF       = 2'h1;
   localparam logic [1:0]  LIM_EITHER    = 2'h2;
   localparam logic [1:0]  STOP_DB       = 2'h0;
   localparam logic [1:0]  STOP_FREE     = 2'h1;
   localparam logic [1:0]  STOP_IMM      = 2'h2;
   localparam logic        UV_SERVO_OFF  = 1'h0;
   localparam logic        UV_ERROR      = 1'h1;
   // 30 mm/s
   localparam logic [15:0] SPEED_STOP_MMS = 16'h001E;
   localparam logic [7:0]  ERR_TRV_MAIN  = 8'h26;
   localparam logic [3:0]  ERR_TRV_SUB   = 4'h0;
   localparam logic [7:0]  ERR_UV_MAIN   = 8'h0D;
   localparam logic [3:0]  ERR_UV_SUB    = 4'h1;
   localparam logic [7:0]  WARN_CMD_CODE = 8'hB1;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam int unsigned CTRL_CLR_ERR  = 0;
   localparam int unsigned CTRL_CLR_WARN = 1;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0]
   {
      TLSC_RUN   = 2'h0,
      TLSC_DECEL = 2'h1,
      TLSC_AFTER = 2'h3,
      TLSC_FAULT = 2'h2
   } tlsc_state_t;

   typedef enum logic [1:0]
   {
      MTH_NONE      = 2'h0,
      MTH_DYN_BRAKE = 2'h1,
      MTH_FREE_RUN  = 2'h2,
      MTH_IMM_STOP  = 2'h3
   } tlsc_method_t;

   typedef struct packed
   {
      logic               pos_closed;
      logic               neg_closed;
      logic               cmd_pos;
      logic               cmd_neg;
      logic               other_fault;
      logic               main_pwr_ok;
      logic signed [15:0] speed_mms;
      logic signed [15:0] force_cmd;
   } tlsc_sense_t;

   localparam tlsc_sense_t SENSE_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
                                         16'h0000, 16'h0000};

   typedef struct packed
   {
      tlsc_method_t       method;
      logic               fault_stop;
      logic               servo_en;
      logic               err_cnt_clear;
      logic               err_cnt_hold;
      logic signed [15:0] force_cmd;
      logic               use_imm_limit;
      logic [15:0]        imm_limit;
      logic               warn_cmd;
      logic [7:0]         err_main;
      logic [3:0]         err_sub;
   } tlsc_act_t;

   typedef struct packed
   {
      logic        awvalid;
      logic [15:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [15:0] araddr;
      logic        rready;
   } tlsc_axi_req_t;

   typedef struct packed
   {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tlsc_axi_rsp_t;

   typedef struct packed
   {
      logic [15:0] lim_sel;
      logic [15:0] stop_sel;
      logic [15:0] uv_sel;
      logic [15:0] imm_force;
      logic        aw_have;
      logic [15:0] awaddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      tlsc_state_t st;
      logic        travel_err;
      logic        uv_err;
      logic        warn;
      tlsc_act_t   act;
   } tlsc_core_st_t;

endpackage

/* logic/tlsc_sample.sv */
`timescale 1ns/1ps
module tlsc_sample
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire tlsc_pkg::tlsc_sense_t sense_in,
   output tlsc_pkg::tlsc_sense_t      sense_q
);
   import tlsc_pkg::*;

   tlsc_sense_t q_r;
   tlsc_sense_t q_nxt;

   // ****************************************
   // one snapshot per control cycle
   // ****************************************
   // per-cycle input snapshot
   always_comb
   begin
      q_nxt = sense_in;
   end

   // limits read as closed in reset so no false error
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q_r <= SENSE_RST;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign sense_q = q_r;

endmodule

/* logic/tlsc_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - With limit selection 0 a travel-limit error is flagged only when both inputs are open.
// - With limit selection 1 both limit inputs are ignored.
// - With limit selection 2 a travel-limit error is flagged when either input is open.
// - With selection 0 an open positive input blocks positive motion only.
// - With selection 0 an open negative input blocks negative motion only.
// - With selection 0 a blocking input starts a stop using the stop selection.
// - With selection 0 and both inputs open, error 38 is raised as a drive fault.
// - With selection 2 error 38.0 is raised and the fault reaction decides the stop.
// - Any other error also hands the stop to the fault reaction.
// - Decel uses dynamic brake, free-run or immediate stop for 0/1/2 and clears the counter.
// - After stop, 0/1 zero the blocked force and hold; 2 passes force, clears once, holds.
// - Decel turns to after-stop at 30 mm/s or less and stays there whatever the speed.
// - Immediate stop keeps the servo on and limits force to the immediate-stop value when that value is non-zero.
// - Command warning B1 is raised for a command into a blocked direction when stopped.
// - The undervoltage selection picks servo-off or stop with error on power loss.
// - Undervoltage 0 turns the servo off until power returns; 1 raises error 13.1.
module tlsc_core
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire tlsc_pkg::tlsc_axi_req_t axi_req,
   output tlsc_pkg::tlsc_axi_rsp_t      axi_rsp,
   input  wire tlsc_pkg::tlsc_sense_t   sense,
   output tlsc_pkg::tlsc_act_t          act
);
   import tlsc_pkg::*;

   tlsc_sense_t   snap;
   tlsc_core_st_t st_r;
   tlsc_core_st_t st_nxt;
   logic [1:0]    sel;
   logic [1:0]    ssel;
   logic          pos_open;
   logic          neg_open;
   logic          pos_blk;
   logic          neg_blk;
   logic          blk;
   logic          slow;
   logic [16:0]   spd_abs;
   logic          trv_evt;
   logic          uv_evt;
   logic          warn_evt;
   logic          fault_any;
   logic          do_wr;
   logic          wr_ctrl;
   logic          wr_ok;
   logic          clr_err;
   logic          clr_warn;
   logic [31:0]   rd_val;
   logic          rd_ok;
   logic [31:0]   status_w;

   function automatic logic [15:0] wmerge
   (
      input logic [15:0] old,
      input logic [31:0] d,
      input logic [3:0]  s
   );
      wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   tlsc_sample tlsc_sample_i
   (
      .clk      (clk),
      .srst     (srst),
      .sense_in (sense),
      .sense_q  (snap)
   );

   // ****************************************
   // limit and speed evaluation
   // ****************************************
   assign sel      = st_r.lim_sel[1:0];
   assign ssel     = st_r.stop_sel[1:0];
   assign pos_open = !snap.pos_closed;
   assign neg_open = !snap.neg_closed;
   assign pos_blk  = (sel == LIM_BOTH) && pos_open;
   assign neg_blk  = (sel == LIM_BOTH) && neg_open;
   assign blk      = pos_blk || neg_blk;
   assign spd_abs  = snap.speed_mms[15] ?
                     17'(-$signed({snap.speed_mms[15], snap.speed_mms})) :
                     {1'b0, snap.speed_mms};
   assign slow     = spd_abs <= {1'b0, SPEED_STOP_MMS};
   // both open error, selection 1 never matches
   assign trv_evt  = ((sel == LIM_BOTH) && pos_open && neg_open) ||
                     ((sel == LIM_EITHER) && (pos_open || neg_open));
   assign uv_evt   = !snap.main_pwr_ok && (st_r.uv_sel[0] == UV_ERROR);
   assign warn_evt = slow && ((pos_blk && snap.cmd_pos) || (neg_blk && snap.cmd_neg));

   // ****************************************
   // register bus decode
   // ****************************************
   assign do_wr    = st_r.aw_have && st_r.w_have;
   assign wr_ctrl  = st_r.awaddr[15:2] == ADR_CTRL[15:2];
   assign clr_err  = do_wr && wr_ctrl && st_r.wstrb[0] && st_r.wdata[CTRL_CLR_ERR];
   assign clr_warn = do_wr && wr_ctrl && st_r.wstrb[0] && st_r.wdata[CTRL_CLR_WARN];

   assign status_w = {st_r.act.warn_cmd ? WARN_CMD_CODE : 8'h00,
                      4'h0, st_r.act.err_sub, st_r.act.err_main,
                      st_r.act.servo_en, neg_blk, pos_blk, st_r.warn,
                      st_r.uv_err, st_r.travel_err, st_r.st};

   always_comb
   begin
      wr_ok = 1'b1;
      if (st_r.awaddr[15:2] == ADR_LIM_SEL[15:2])
      begin
         wr_ok = 1'b1;
      end
      else if (st_r.awaddr[15:2] == ADR_STOP_SEL[15:2])
      begin
         wr_ok = 1'b1;
      end
      else if (st_r.awaddr[15:2] == ADR_UV_SEL[15:2])
      begin
         wr_ok = 1'b1;
      end
      else if (st_r.awaddr[15:2] == ADR_IMM_FORCE[15:2])
      begin
         wr_ok = 1'b1;
      end
      else if (wr_ctrl)
      begin
         wr_ok = 1'b1;
      end
      else
      begin
         wr_ok = 1'b0;
      end
   end

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (axi_req.araddr[15:2] == ADR_LIM_SEL[15:2])
      begin
         rd_val = {16'h0000, st_r.lim_sel};
      end
      else if (axi_req.araddr[15:2] == ADR_STOP_SEL[15:2])
      begin
         rd_val = {16'h0000, st_r.stop_sel};
      end
      else if (axi_req.araddr[15:2] == ADR_UV_SEL[15:2])
      begin
         rd_val = {16'h0000, st_r.uv_sel};
      end
      else if (axi_req.araddr[15:2] == ADR_IMM_FORCE[15:2])
      begin
         rd_val = {16'h0000, st_r.imm_force};
      end
      else if (axi_req.araddr[15:2] == ADR_STATUS[15:2])
      begin
         rd_val = status_w;
      end
      else if (axi_req.araddr[15:2] == ADR_CTRL[15:2])
      begin
         rd_val = 32'h0000_0000;
      end
      else
      begin
         rd_ok = 1'b0;
      end
   end

   always_comb
   begin
      axi_rsp.awready = !st_r.aw_have && !st_r.bvalid;
      axi_rsp.wready  = !st_r.w_have && !st_r.bvalid;
      axi_rsp.bvalid  = st_r.bvalid;
      axi_rsp.bresp   = st_r.bresp;
      axi_rsp.arready = !st_r.rvalid;
      axi_rsp.rvalid  = st_r.rvalid;
      axi_rsp.rdata   = st_r.rdata;
      axi_rsp.rresp   = st_r.rresp;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      if (axi_req.awvalid && axi_rsp.awready)
      begin
         st_nxt.aw_have = 1'b1;
         st_nxt.awaddr  = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
         st_nxt.w_have = 1'b1;
         st_nxt.wdata  = axi_req.wdata;
         st_nxt.wstrb  = axi_req.wstrb;
      end
      if (st_r.bvalid && axi_req.bready)
      begin
         st_nxt.bvalid = 1'b0;
      end
      if (do_wr)
      begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
         if (st_r.awaddr[15:2] == ADR_LIM_SEL[15:2])
         begin
            st_nxt.lim_sel = wmerge(st_r.lim_sel, st_r.wdata, st_r.wstrb);
         end
         else if (st_r.awaddr[15:2] == ADR_STOP_SEL[15:2])
         begin
            st_nxt.stop_sel = wmerge(st_r.stop_sel, st_r.wdata, st_r.wstrb);
         end
         else if (st_r.awaddr[15:2] == ADR_UV_SEL[15:2])
         begin
            st_nxt.uv_sel = wmerge(st_r.uv_sel, st_r.wdata, st_r.wstrb);
         end
         else if (st_r.awaddr[15:2] == ADR_IMM_FORCE[15:2])
         begin
            st_nxt.imm_force = wmerge(st_r.imm_force, st_r.wdata, st_r.wstrb);
         end
      end
      if (st_r.rvalid && axi_req.rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      if (axi_req.arvalid && axi_rsp.arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_val;
         st_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // sticky flags: a new event beats a clear in the same cycle
      // error 38 latched as a drive fault
      st_nxt.travel_err = (st_r.travel_err && !clr_err) || trv_evt;
      st_nxt.uv_err     = (st_r.uv_err && !clr_err) || uv_evt;
      st_nxt.warn       = (st_r.warn && !clr_warn) || warn_evt;
      // any error hands over to the fault reaction
      fault_any = st_nxt.travel_err || st_nxt.uv_err || snap.other_fault;

      case (st_r.st)
         TLSC_RUN:
         begin
            if (fault_any)
            begin
               st_nxt.st = TLSC_FAULT;
            end
            else if (blk)
            begin
               st_nxt.st = TLSC_DECEL;
            end
         end
         TLSC_DECEL:
         begin
            if (fault_any)
            begin
               st_nxt.st = TLSC_FAULT;
            end
            else if (!blk)
            begin
               st_nxt.st = TLSC_RUN;
            end
            else if (slow)
            begin
               st_nxt.st = TLSC_AFTER;
            end
         end
         TLSC_AFTER:
         begin
            if (fault_any)
            begin
               st_nxt.st = TLSC_FAULT;
            end
            else if (!blk)
            begin
               st_nxt.st = TLSC_RUN;
            end
         end
         default:
         begin
            // leaves once latched errors are cleared by software and other_fault is low
            if (!fault_any)
            begin
               st_nxt.st = TLSC_RUN;
            end
         end
      endcase

      // ****************************************
      // actuation outputs
      // ****************************************
      st_nxt.act.method        = MTH_NONE;
      // fault reaction takes over, stop selection ignored
      st_nxt.act.fault_stop    = st_nxt.st == TLSC_FAULT;
      st_nxt.act.servo_en      = snap.main_pwr_ok || (st_r.uv_sel[0] == UV_ERROR);
      st_nxt.act.err_cnt_clear = 1'b0;
      st_nxt.act.err_cnt_hold  = 1'b0;
      st_nxt.act.force_cmd     = snap.force_cmd;
      st_nxt.act.use_imm_limit = 1'b0;
      st_nxt.act.imm_limit     = st_r.imm_force;
      st_nxt.act.warn_cmd      = st_nxt.warn;
      st_nxt.act.err_main      = st_nxt.travel_err ? ERR_TRV_MAIN :
                                 st_nxt.uv_err ? ERR_UV_MAIN : 8'h00;
      st_nxt.act.err_sub       = st_nxt.travel_err ? ERR_TRV_SUB :
                                 st_nxt.uv_err ? ERR_UV_SUB : 4'h0;
      if (st_nxt.st == TLSC_DECEL)
      begin
         // method per stop selection, counter cleared
         st_nxt.act.err_cnt_clear = 1'b1;
         if (ssel == STOP_IMM)
         begin
            // closed-loop stop, servo stays on, force limited when imm_force is non-zero
            st_nxt.act.method        = MTH_IMM_STOP;
            st_nxt.act.use_imm_limit = st_r.imm_force != 16'h0000;
         end
         else
         begin
            st_nxt.act.method    = (ssel == STOP_FREE) ? MTH_FREE_RUN : MTH_DYN_BRAKE;
            st_nxt.act.servo_en  = 1'b0;
            st_nxt.act.force_cmd = 16'sh0000;
         end
      end
      else if (st_nxt.st == TLSC_AFTER)
      begin
         if (ssel != STOP_IMM)
         begin
            st_nxt.act.err_cnt_hold = 1'b1;
            if ((pos_blk && (snap.force_cmd > 0)) || (neg_blk && (snap.force_cmd < 0)))
            begin
               st_nxt.act.force_cmd = 16'sh0000;
            end
         end
         else if (st_r.st == TLSC_DECEL)
         begin
            st_nxt.act.err_cnt_clear = 1'b1;
         end
         else
         begin
            st_nxt.act.err_cnt_hold = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_r           <= '0;
         st_r.lim_sel   <= RST_LIM_SEL;
         st_r.stop_sel  <= RST_STOP_SEL;
         st_r.uv_sel    <= RST_UV_SEL;
         st_r.imm_force <= RST_IMM_FORCE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign act = st_r.act;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_sample_one_cycle: assert property (
      !srst |=> snap == $past(sense))
      else $error("inputs not sampled once per cycle");
   a_both_open_err: assert property (
      (sel == LIM_BOTH) && pos_open && neg_open
      |=> st_r.travel_err && (st_r.act.err_main == ERR_TRV_MAIN) && st_r.act.fault_stop)
      else $error("both open did not raise travel error");
   a_sel_off_quiet: assert property (
      (sel == LIM_OFF) && !st_r.travel_err |=> !st_r.travel_err)
      else $error("disabled inputs raised travel error");
   a_either_open_err: assert property (
      (sel == LIM_EITHER) && (pos_open || neg_open)
      |=> st_r.travel_err && (st_r.act.err_sub == ERR_TRV_SUB) && st_r.act.fault_stop)
      else $error("one open input did not raise error in strict mode");
   a_one_side_ok: assert property (
      (sel == LIM_BOTH) && pos_open && !neg_open && !st_r.travel_err
      |=> !st_r.travel_err)
      else $error("single open input raised error");
   a_decel_entry: assert property (
      (st_r.st == TLSC_RUN) && blk && !fault_any
      |=> (st_r.st == TLSC_DECEL) && st_r.act.err_cnt_clear && (st_r.act.method != MTH_NONE))
      else $error("blocking input did not start decel");
   a_after_entry: assert property (
      (st_r.st == TLSC_DECEL) && slow && blk && !fault_any |=> st_r.st == TLSC_AFTER)
      else $error("slow decel did not reach after-stop");
   a_after_stays: assert property (
      (st_r.st == TLSC_AFTER) && blk && !fault_any |=> st_r.st == TLSC_AFTER)
      else $error("after-stop left while still blocked");
   a_after_hold: assert property (
      (st_r.st == TLSC_AFTER) && ($past(st_r.st) == TLSC_AFTER)
      |-> !st_r.act.err_cnt_clear && st_r.act.err_cnt_hold)
      else $error("counter not held after stop");
   a_zero_force: assert property (
      (st_r.st == TLSC_AFTER) && (ssel != STOP_IMM) && pos_blk && (snap.force_cmd > 0)
      && !fault_any |=> st_r.act.force_cmd == 16'sh0000)
      else $error("force into blocked side not zeroed");
   a_warn_set: assert property (
      warn_evt |=> st_r.warn && st_r.act.warn_cmd && (status_w[31:24] == WARN_CMD_CODE))
      else $error("command warning not raised");
   a_uv_error: assert property (
      (st_r.uv_sel[0] == UV_ERROR) && !snap.main_pwr_ok
      |=> st_r.uv_err && st_r.act.fault_stop
          && (st_r.act.err_sub == (st_r.travel_err ? ERR_TRV_SUB : ERR_UV_SUB)))
      else $error("undervoltage error not raised");
   a_uv_servo_off: assert property (
      (st_r.uv_sel[0] == UV_SERVO_OFF) && !snap.main_pwr_ok |=> !st_r.act.servo_en)
      else $error("servo kept on during power loss");
   a_fault_wins: assert property (
      snap.other_fault |=> (st_r.st == TLSC_FAULT) && (st_r.act.method == MTH_NONE))
      else $error("fault reaction did not take precedence");

   c_decel_after: cover property ((st_r.st == TLSC_DECEL) ##1 (st_r.st == TLSC_AFTER));
   c_travel_err: cover property ($rose(st_r.travel_err));
   c_warn: cover property ($rose(st_r.warn));
   c_imm_stop: cover property (st_r.act.method == MTH_IMM_STOP);

endmodule

/* tb/tlsc_axis_model.sv */
`timescale 1ns/1ps
module tlsc_axis_model
(
   input  wire logic               pos_open,
   input  wire logic               neg_open,
   input  wire logic               cmd_p,
   input  wire logic               cmd_n,
   input  wire logic               oth_flt,
   input  wire logic               pwr_off,
   input  wire logic signed [15:0] speed,
   output tlsc_pkg::tlsc_sense_t   sense
);
   import tlsc_pkg::*;
   // open switch reads low, so a cut wire also trips
   // force held positive, so only the positive side gets masked
   assign sense = '{!pos_open, !neg_open, cmd_p, cmd_n, oth_flt, !pwr_off, speed, 16'h0064};
endmodule

/* tb/travel_limit_stop_control_bench.sv */
`timescale 1ns/1ps
module travel_limit_stop_control_bench;
   import tlsc_pkg::*;
   logic               clk = 1'b0;
   logic               srst = 1'b1;
   tlsc_axi_req_t      rq;
   tlsc_axi_rsp_t      rs;
   tlsc_sense_t        sn;
   tlsc_act_t          ac;
   logic               po;
   logic               ne;
   logic               cp;
   logic               pf;
   logic               cn;
   logic               ofl;
   logic signed [15:0] spd;
   logic [31:0]        d;
   logic [1:0]         r;
   int                 num_errors = 0;
   int                 n_tests = 0;
   tlsc_method_t       mt [3] = '{MTH_DYN_BRAKE, MTH_FREE_RUN, MTH_IMM_STOP};

   always #50 clk = !clk;

   tlsc_core tlsc_core_i (.clk(clk), .srst(srst), .axi_req(rq), .axi_rsp(rs),
      .sense(sn), .act(ac));
   tlsc_axis_model tlsc_axis_model_i (.pos_open(po), .neg_open(ne), .cmd_p(cp),
      .cmd_n(cn), .oth_flt(ofl), .pwr_off(pf), .speed(spd), .sense(sn));

   // ****************************************
   // helpers
   // ****************************************
   task automatic complete_run;
      begin
         $display("errors %0d checks %0d", num_errors, n_tests);
         if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      begin
         n_tests++;
         if (g !== e)
         begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // bready and rready stay high, so the answer edge is the handshake
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      int n;
      begin
         rq.awvalid <= 1'b1;
         rq.wvalid <= 1'b1;
         rq.awaddr <= a;
         rq.wdata <= v;
         rq.wstrb <= 4'hF;
         n = 0;
         do
         begin
            @(posedge clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
            n++;
         end
         while (rs.bvalid !== 1'b1 && n < 40);
         if (n >= 40) ck(32'h0, 32'h1);
         if (n >= 40) complete_run();
      end
   endtask

   task automatic rd(input logic [15:0] a);
      int n;
      begin
         rq.arvalid <= 1'b1;
         rq.araddr <= a;
         n = 0;
         do
         begin
            @(posedge clk);
            if (rs.arready) rq.arvalid <= 1'b0;
            n++;
         end
         while (rs.rvalid !== 1'b1 && n < 40);
         d = rs.rdata;
         r = rs.rresp;
         if (n >= 40) ck(32'h0, 32'h1);
         if (n >= 40) complete_run();
      end
   endtask

   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      rq <= '{bready: 1'b1, rready: 1'b1, default: '0};
      {po, ne, cp, cn, pf, ofl} <= 6'h00;
      spd <= 16'sh0000;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(ADR_LIM_SEL);
      ck(d, 32'h1);
      rd(ADR_STOP_SEL);
      ck(d, 32'h0);
      rd(ADR_UV_SEL);
      ck(d, 32'h1);
      rd(16'h0100);
      ck(32'(r), 32'(RESP_SLVERR));
      {po, ne} <= 2'h3;
      cyc(4);
      rd(ADR_STATUS);
      ck(32'(d[2]), 32'h0);
      wr(ADR_LIM_SEL, 32'h0);
      cyc(4);
      rd(ADR_STATUS);
      ck(32'(d[15:8]), 32'(ERR_TRV_MAIN));
      {po, ne} <= 2'h0;
      cyc(3);
      wr(ADR_CTRL, 32'h1);
      wr(ADR_IMM_FORCE, 32'h1F4);
      for (int s = 0; s < 3; s++)
      begin
         wr(ADR_STOP_SEL, 32'(s));
         spd <= 16'sh01F4;
         po <= 1'b1;
         cyc(4);
         ck(32'(ac.method), 32'(mt[s]));
         ck(32'(ac.servo_en), 32'(s == 2));
         ck(32'(ac.err_cnt_clear), 32'h1);
         ck(32'(ac.use_imm_limit), 32'(s == 2));
         ck(32'(ac.imm_limit), 32'h1F4);
         spd <= 16'sh0014;
         cp <= 1'b1;
         cyc(5);
         rd(ADR_STATUS);
         ck(32'(d[4:0]), 32'h13);
         ck(32'(d[31:24]), 32'(WARN_CMD_CODE));
         spd <= 16'sh01F4;
         cyc(4);
         rd(ADR_STATUS);
         ck(32'(d[1:0]), 32'h3);
         ck(32'(ac.force_cmd), (s == 2) ? 32'h64 : 32'h0);
         ck(32'(ac.err_cnt_hold), 32'h1);
         {po, cp} <= 2'h0;
         cyc(3);
         wr(ADR_CTRL, 32'h2);
      end
      ne <= 1'b1;
      cyc(4);
      rd(ADR_STATUS);
      ck(32'(d[7:0]), 32'hC1);
      spd <= 16'sh0014;
      cn <= 1'b1;
      cyc(5);
      rd(ADR_STATUS);
      ck(32'(d[6:0]), 32'h53);
      ofl <= 1'b1;
      cyc(4);
      ck(32'({ac.fault_stop, ac.method}), 32'h4);
      {ne, cn, ofl} <= 3'h0;
      cyc(3);
      wr(ADR_CTRL, 32'h2);
      wr(ADR_LIM_SEL, 32'h2);
      ne <= 1'b1;
      cyc(4);
      ck(32'(ac.fault_stop), 32'h1);
      ck(32'(ac.err_main), 32'(ERR_TRV_MAIN));
      ne <= 1'b0;
      cyc(3);
      wr(ADR_CTRL, 32'h1);
      pf <= 1'b1;
      cyc(4);
      ck(32'(ac.err_sub), 32'(ERR_UV_SUB));
      pf <= 1'b0;
      cyc(3);
      wr(ADR_CTRL, 32'h1);
      wr(ADR_UV_SEL, 32'h0);
      pf <= 1'b1;
      cyc(4);
      ck(32'({ac.servo_en, ac.err_main}), 32'h0);
      pf <= 1'b0;
      cyc(4);
      ck(32'(ac.servo_en), 32'h1);
      complete_run();
   end
endmodule
